// *** rtl/exs_pkg.sv ***
// Package of constants for the exception syndrome encoder
package exs_pkg;
   // Exception levels
   localparam logic [1:0] EXS_LVL_APP = 2'h0;
   localparam logic [1:0] EXS_LVL_KERN = 2'h1;
   localparam logic [1:0] EXS_LVL_HYP = 2'h2;
   localparam logic [1:0] EXS_LVL_MON = 2'h3;
   // Exception class codes
   localparam logic [5:0] EXS_EC_RET_TRAP = 6'h1A;
   localparam logic [5:0] EXS_EC_TXN_BEGIN = 6'h1B;
   localparam logic [5:0] EXS_EC_BRANCH_TGT = 6'h0D;
   localparam logic [5:0] EXS_EC_PAUTH_TRAP = 6'h09;
   localparam logic [5:0] EXS_EC_PAUTH_FAIL = 6'h1C;
   localparam logic [5:0] EXS_EC_SYSREG = 6'h18;
   localparam logic [5:0] EXS_EC_IABT_LO = 6'h20;
   localparam logic [5:0] EXS_EC_IABT_CUR = 6'h21;
   localparam logic [5:0] EXS_EC_DABT_LO = 6'h24;
   localparam logic [5:0] EXS_EC_DABT_CUR = 6'h25;
   // Syndrome field positions
   localparam int EXS_EC_LSB = 26;
   localparam int EXS_IL_BIT = 25;
   localparam int EXS_RD_LSB = 5;
   localparam int EXS_EXT_LSB = 32;
   localparam int EXS_EXT_W = 24;
   localparam int EXS_XS_W = 5;
   // System register encoding, op0 op1 crn crm op2 packed
   localparam logic [15:0] EXS_ENC_HYP = 16'hE290;
   localparam logic [15:0] EXS_ENC_KERN = 16'hC290;
   localparam logic [15:0] EXS_ENC_MON = 16'hF290;
   // Redirect offset into nested-virtualization memory area
   localparam logic [11:0] EXS_NESTED_VIRT_MEMORY_AREA_OFS = 12'h138;
   // Abort fault kinds; all but EXS_FLT_OTHER carry the status register number
   localparam logic [1:0] EXS_FLT_OTHER = 2'h0;
   localparam logic [1:0] EXS_FLT_TRANS = 2'h1;
   localparam logic [1:0] EXS_FLT_ACCESS = 2'h2;
   localparam logic [1:0] EXS_FLT_PERM = 2'h3;
   // Event kinds presented to the encoder
   typedef enum logic [7:0] {
      EXS_EV_RET = 8'h01,
      EXS_EV_TXN = 8'h02,
      EXS_EV_BTI = 8'h04,
      EXS_EV_PTRAP = 8'h08,
      EXS_EV_PFAIL = 8'h10,
      EXS_EV_DABT = 8'h20,
      EXS_EV_IABT = 8'h40,
      EXS_EV_NONE = 8'h80
   } exs_event_t;
   // Outcome of a register access
   typedef enum logic [4:0] {
      EXS_AC_OK = 5'h01,
      EXS_AC_UNDEF = 5'h02,
      EXS_AC_TRAP = 5'h04,
      EXS_AC_MEM = 5'h08,
      EXS_AC_IDLE = 5'h10
   } exs_acc_t;
endpackage

// *** rtl/exs_synd_reg.sv ***
// Single 64-bit syndrome storage word with registered read data
`timescale 1ns/1ps
module exs_synd_reg
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Write ports, exception capture wins over software
   input wire logic hw_we_i,
   input wire logic [63:0] hw_data_i,
   input wire logic sw_we_i,
   input wire logic [63:0] sw_data_i,
   // Contents
   output logic [63:0] q_o
);
   logic [63:0] next_q;

   // Capture beats a software write landing in the same cycle
   always_comb
   begin
      next_q = q_o;
      if (sw_we_i)
         next_q = sw_data_i;
      if (hw_we_i)
         next_q = hw_data_i;
   end

   // No reset: contents are kept through a warm reset
   always_ff @(posedge clk_i)
   begin
      q_o <= next_q;
   end
endmodule

// *** rtl/exs_syndrome.sv ***
// Syndrome encoder and syndrome register access control
`timescale 1ns/1ps
module exs_syndrome
   import exs_pkg::*;
#(
   parameter bit HAS_MONITOR = 1'b1,
   parameter bit HAS_FINE_TRAP = 1'b1
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Exception event
   input wire logic exc_valid_i,
   input wire exs_event_t exc_kind_i,
   input wire logic [1:0] exc_target_i,
   input wire logic [5:0] exc_class_i,
   input wire logic exc_il_i,
   input wire logic ret_auth_i,
   input wire logic ret_b_key_i,
   input wire logic [4:0] txn_dest_reg_i,
   input wire logic [1:0] branch_kind_state_i,
   input wire logic auth_fail_i,
   input wire logic auth_data_key_i,
   input wire logic auth_b_key_i,
   input wire logic wide_store_i,
   input wire logic [1:0] abort_fault_i,
   input wire logic [4:0] store_status_register_number_i,
   input wire logic monitor_return_i,
   // Control bits
   input wire logic hyp_enabled_i,
   input wire logic nested_virt_bit_i,
   input wire logic nested_virt_kernel_bit_i,
   input wire logic nested_virt_memory_bit_i,
   input wire logic host_extension_bit_i,
   input wire logic vm_read_trap_bit_i,
   input wire logic vm_write_trap_bit_i,
   input wire logic fine_grain_trap_enable_i,
   input wire logic fine_grain_read_trap_i,
   input wire logic fine_grain_write_trap_i,
   // System register access
   input wire logic acc_valid_i,
   input wire logic acc_write_i,
   input wire logic [1:0] acc_level_i,
   input wire logic [15:0] acc_enc_i,
   input wire logic [63:0] acc_wdata_i,
   // Access answer
   output exs_acc_t acc_result_o,
   output logic [63:0] acc_rdata_o,
   output logic [11:0] acc_mem_ofs_o,
   output logic [5:0] acc_trap_class_o,
   // Raised exceptions
   output logic auth_exc_o,
   output logic [63:0] hyp_syndrome_o
);
   logic [63:0] next_synd;
   logic next_synd_ok;
   logic [63:0] kern_q;
   logic [63:0] hyp_q;
   logic [63:0] mon_q;
   logic hit_hyp;
   logic hit_kern;
   logic fine_on;
   exs_acc_t next_result;
   logic [63:0] next_rdata;
   logic [11:0] next_ofs;
   logic [5:0] next_tclass;
   logic next_auth_exc;
   logic kern_sw_we;
   logic hyp_sw_we;
   logic mon_sw_we;
   logic [63:0] next_mon_data;

   // Class and IL into the upper half of the low word
   function automatic logic [63:0] exs_head(input logic [5:0] ec, input logic il);
      logic [63:0] w;
      w = 64'h0;
      w[EXS_EC_LSB +: 6] = ec;
      w[EXS_IL_BIT] = il;
      return w;
   endfunction

   // Syndrome formation per event kind; reserved bits stay zero
   always_comb
   begin
      next_synd = exs_head(exc_class_i, exc_il_i);
      next_synd_ok = exc_valid_i;
      next_auth_exc = exc_valid_i && (exc_kind_i == EXS_EV_PFAIL) && auth_fail_i;
      unique case (exc_kind_i)
         EXS_EV_RET:
         begin
            // Layout unusable without fine traps or nested bit
            next_synd_ok = exc_valid_i && (HAS_FINE_TRAP || nested_virt_bit_i);
            next_synd[1] = ret_auth_i;
            next_synd[0] = ret_auth_i && ret_b_key_i;
         end
         EXS_EV_TXN:
            next_synd[EXS_RD_LSB +: 5] = txn_dest_reg_i;
         EXS_EV_BTI:
            next_synd[1:0] = branch_kind_state_i;
         EXS_EV_PFAIL:
         begin
            next_synd[1] = auth_data_key_i;
            next_synd[0] = auth_b_key_i;
         end
         EXS_EV_DABT:
         begin
            // Only wide-store faults of the listed kinds carry the number
            if (((exc_class_i == EXS_EC_DABT_LO) || (exc_class_i == EXS_EC_DABT_CUR))
                && wide_store_i && (abort_fault_i != EXS_FLT_OTHER))
               next_synd[EXS_EXT_LSB +: EXS_XS_W] = store_status_register_number_i;
         end
         EXS_EV_PTRAP, EXS_EV_IABT: // Trap layout is all reserved zero
            next_synd[EXS_EXT_LSB +: EXS_EXT_W] = 24'h0;
         default:
            next_synd_ok = 1'b0;
      endcase
   end

   // Access decode
   always_comb
   begin
      hit_hyp = (acc_enc_i == EXS_ENC_HYP);
      hit_kern = (acc_enc_i == EXS_ENC_KERN);
      fine_on = HAS_FINE_TRAP && hyp_enabled_i
                && (!HAS_MONITOR || fine_grain_trap_enable_i);
      next_result = acc_valid_i ? EXS_AC_UNDEF : EXS_AC_IDLE;
      next_rdata = 64'h0;
      next_ofs = 12'h0;
      next_tclass = 6'h0;
      kern_sw_we = 1'b0;
      hyp_sw_we = 1'b0;
      mon_sw_we = 1'b0;
      if (acc_valid_i && (acc_level_i == EXS_LVL_APP))
         next_result = EXS_AC_UNDEF;
      else if (acc_valid_i && hit_hyp)
      begin
         if (acc_level_i == EXS_LVL_KERN)
         begin
            if (hyp_enabled_i && nested_virt_memory_bit_i && nested_virt_bit_i)
            begin
               // Nested guest sees its own kernel syndrome
               next_result = EXS_AC_OK;
               next_rdata = kern_q;
               kern_sw_we = acc_write_i;
            end
            else if (hyp_enabled_i && nested_virt_bit_i)
            begin
               next_result = EXS_AC_TRAP;
               next_tclass = EXS_EC_SYSREG;
            end
         end
         else
         begin
            next_result = EXS_AC_OK;
            next_rdata = hyp_q;
            hyp_sw_we = acc_write_i;
         end
      end
      else if (acc_valid_i && hit_kern)
      begin
         next_result = EXS_AC_OK;
         if (acc_level_i == EXS_LVL_KERN)
         begin
            if (hyp_enabled_i && (acc_write_i ? vm_write_trap_bit_i : vm_read_trap_bit_i))
            begin
               next_result = EXS_AC_TRAP;
               next_tclass = EXS_EC_SYSREG;
            end
            else if (fine_on && (acc_write_i ? fine_grain_write_trap_i
                                             : fine_grain_read_trap_i))
            begin
               next_result = EXS_AC_TRAP;
               next_tclass = EXS_EC_SYSREG;
            end
            else if (hyp_enabled_i && nested_virt_memory_bit_i && nested_virt_kernel_bit_i
                     && nested_virt_bit_i)
            begin
               // Memory side completes the transfer outside this block
               next_result = EXS_AC_MEM;
               next_ofs = EXS_NESTED_VIRT_MEMORY_AREA_OFS;
            end
            else
            begin
               next_rdata = kern_q;
               kern_sw_we = acc_write_i;
            end
         end
         else if ((acc_level_i == EXS_LVL_HYP) && host_extension_bit_i)
         begin
            // Alias: no ordering promise between the two names
            next_rdata = hyp_q;
            hyp_sw_we = acc_write_i;
         end
         else
         begin
            next_rdata = kern_q;
            kern_sw_we = acc_write_i;
         end
      end
      else if (acc_valid_i && (acc_enc_i == EXS_ENC_MON))
      begin
         // Monitor register reachable only at monitor level when built
         if (HAS_MONITOR && (acc_level_i == EXS_LVL_MON))
         begin
            next_result = EXS_AC_OK;
            next_rdata = mon_q;
            mon_sw_we = acc_write_i;
         end
      end
      if (acc_write_i)
         next_rdata = 64'h0;
   end

   // Monitor data: top byte forced zero on every path in
   always_comb
   begin
      next_mon_data = next_synd;
      next_mon_data[63:56] = 8'h0;
      // Return from monitor inverts the low 56 bits of the contents
      if (monitor_return_i)
         next_mon_data = {8'h0, ~mon_q[55:0]};
   end

   // Storage words; none take a reset value
   exs_synd_reg u_kern
   (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .hw_we_i(next_synd_ok && (exc_target_i == EXS_LVL_KERN)),
      .hw_data_i(next_synd),
      .sw_we_i(kern_sw_we),
      .sw_data_i(acc_wdata_i),
      .q_o(kern_q)
   );

   exs_synd_reg u_hyp
   (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .hw_we_i(next_synd_ok && (exc_target_i == EXS_LVL_HYP)),
      .hw_data_i(next_synd),
      .sw_we_i(hyp_sw_we),
      .sw_data_i(acc_wdata_i),
      .q_o(hyp_q)
   );

   exs_synd_reg u_mon
   (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .hw_we_i((next_synd_ok && HAS_MONITOR && (exc_target_i == EXS_LVL_MON))
               || monitor_return_i),
      .hw_data_i(next_mon_data),
      .sw_we_i(mon_sw_we),
      .sw_data_i({8'h0, acc_wdata_i[55:0]}),
      .q_o(mon_q)
   );

   // Registered access answer; syndrome words keep no reset
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         acc_result_o <= EXS_AC_IDLE;
         acc_rdata_o <= 64'h0;
         acc_mem_ofs_o <= 12'h0;
         acc_trap_class_o <= 6'h0;
         auth_exc_o <= 1'b0;
      end
      else
      begin
         acc_result_o <= next_result;
         acc_rdata_o <= next_rdata;
         acc_mem_ofs_o <= next_ofs;
         acc_trap_class_o <= next_tclass;
         auth_exc_o <= next_auth_exc;
      end
   end

   assign hyp_syndrome_o = hyp_q;
   // Plain return trap leaves bit 0 clear
   ret_key_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (exc_valid_i && exc_kind_i == EXS_EV_RET && !ret_auth_i
       && exc_target_i == EXS_LVL_HYP && nested_virt_bit_i)
      |=> (hyp_q[1:0] == 2'b00)) else $error("return trap key bit set");
   // Auth failure key bits copied
   auth_keys_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (exc_valid_i && exc_kind_i == EXS_EV_PFAIL && exc_target_i == EXS_LVL_HYP)
      |=> (hyp_q[1:0] == {$past(auth_data_key_i), $past(auth_b_key_i)}))
      else $error("auth key bits wrong");
   // Application level never succeeds
   app_undef_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (acc_valid_i && acc_level_i == EXS_LVL_APP) |=> (acc_result_o == EXS_AC_UNDEF))
      else $error("application access not undefined");
   // Read trap answers with class 0x18
   vm_trap_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (acc_valid_i && hit_kern && acc_level_i == EXS_LVL_KERN && hyp_enabled_i
       && !acc_write_i && vm_read_trap_bit_i)
      |=> (acc_result_o == EXS_AC_TRAP && acc_trap_class_o == EXS_EC_SYSREG))
      else $error("read trap missed");
   // Monitor top byte zero
   mon_top_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $past(mon_sw_we) |-> (mon_q[63:56] == 8'h0)) else $error("monitor top byte set");
   // Authentication exception one cycle after failure
   auth_exc_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (exc_valid_i && exc_kind_i == EXS_EV_PFAIL && auth_fail_i) |=> auth_exc_o)
      else $error("auth exception missing");
   // Redirect carries offset
   nv_redirect_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (acc_result_o == EXS_AC_MEM) |-> (acc_mem_ofs_o == EXS_NESTED_VIRT_MEMORY_AREA_OFS))
      else $error("redirect offset wrong");
   // Transaction destination placed
   txn_dest_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (exc_valid_i && exc_kind_i == EXS_EV_TXN && exc_target_i == EXS_LVL_HYP)
      |=> (hyp_q[9:0] == {$past(txn_dest_reg_i), 5'h0})) else $error("dest reg wrong");
endmodule

// *** testbench/exs_syndrome_tb_top.sv ***
// Self-checking testbench for the exception syndrome encoder
`timescale 1ns/1ps
module exs_syndrome_tb_top;
   import exs_pkg::*;
   // Stimulus, all given a value at time zero; read capture rd starts unknown
   logic clk_i = 1'b0, rst_b_i = 1'b0, exc_valid_i = 1'b0, exc_il_i = 1'b1;
   exs_event_t exc_kind_i = EXS_EV_NONE;
   logic [1:0] exc_target_i = 2'h0, branch_kind_state_i = 2'h0, abort_fault_i = 2'h0;
   logic [5:0] exc_class_i = 6'h00;
   logic ret_auth_i = 1'b0, ret_b_key_i = 1'b0, auth_fail_i = 1'b0, auth_data_key_i = 1'b0;
   logic auth_b_key_i = 1'b0, wide_store_i = 1'b0, monitor_return_i = 1'b0;
   logic [4:0] txn_dest_reg_i = 5'h00, store_status_register_number_i = 5'h00;
   logic hyp_enabled_i = 1'b1, nested_virt_bit_i = 1'b0, nested_virt_kernel_bit_i = 1'b0;
   logic nested_virt_memory_bit_i = 1'b0, host_extension_bit_i = 1'b0;
   logic vm_read_trap_bit_i = 1'b0, vm_write_trap_bit_i = 1'b0, fine_grain_trap_enable_i = 1'b0;
   logic fine_grain_read_trap_i = 1'b0, fine_grain_write_trap_i = 1'b0;
   logic acc_valid_i = 1'b0, acc_write_i = 1'b0;
   logic [1:0] acc_level_i = 2'h0;
   logic [15:0] acc_enc_i = 16'h0000;
   logic [63:0] acc_wdata_i = 64'h0, rd;
   // Observed outputs
   exs_acc_t acc_result_o;
   logic [63:0] acc_rdata_o, hyp_syndrome_o;
   logic [11:0] acc_mem_ofs_o;
   logic [5:0] acc_trap_class_o;
   logic auth_exc_o;
   int errors = 0, checks = 0, cycles = 0;
   // Monitor name: op1 of 110, otherwise as the hypervisor one
   localparam logic [15:0] ENC_MON = {2'h3, 3'h6, 4'h5, 4'h2, 3'h0};

   exs_syndrome i_dut (.clk_i, .rst_b_i, .exc_valid_i, .exc_kind_i, .exc_target_i,
      .exc_class_i, .exc_il_i, .ret_auth_i, .ret_b_key_i, .txn_dest_reg_i,
      .branch_kind_state_i, .auth_fail_i, .auth_data_key_i, .auth_b_key_i, .wide_store_i,
      .abort_fault_i, .store_status_register_number_i, .monitor_return_i, .hyp_enabled_i,
      .nested_virt_bit_i, .nested_virt_kernel_bit_i, .nested_virt_memory_bit_i,
      .host_extension_bit_i, .vm_read_trap_bit_i, .vm_write_trap_bit_i,
      .fine_grain_trap_enable_i, .fine_grain_read_trap_i, .fine_grain_write_trap_i,
      .acc_valid_i, .acc_write_i, .acc_level_i, .acc_enc_i, .acc_wdata_i, .acc_result_o,
      .acc_rdata_o, .acc_mem_ofs_o, .acc_trap_class_o, .auth_exc_o, .hyp_syndrome_o);

   // Clock, 25 ns period
   initial
   begin
      forever #12.5 clk_i = ~clk_i;
   end

   // Hang guard, the whole run needs about a hundred cycles
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         give_verdict();
      end
   end

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Low syndrome word: class, long-instruction bit, then the layout
   function automatic logic [63:0] synd(input logic [5:0] c, input logic [24:0] iss);
      return {32'h0, c, 1'b1, iss};
   endfunction

   // One exception, held for one edge; captured word visible after it
   task automatic exc(input exs_event_t k, input logic [1:0] t, input logic [5:0] c);
      @(posedge clk_i);
      #1 exc_valid_i = 1'b1;
      exc_kind_i = k;
      exc_target_i = t;
      exc_class_i = c;
      @(posedge clk_i);
      #1 exc_valid_i = 1'b0;
   endtask

   // One register access; answer stands only in the cycle after the taking edge
   task automatic acc(input logic [1:0] l, input logic w, input logic [15:0] e,
      input logic [63:0] d, input exs_acc_t exp);
      @(posedge clk_i);
      #1 acc_valid_i = 1'b1;
      acc_level_i = l;
      acc_write_i = w;
      acc_enc_i = e;
      acc_wdata_i = d;
      @(posedge clk_i);
      #1 acc_valid_i = 1'b0;
      check("access result", 64'(acc_result_o), 64'(exp));
      rd = acc_rdata_o;
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (4) @(posedge clk_i);
      #1 rst_b_i = 1'b1;
      // Return traps, every variant, with and without the nested bit
      for (int i = 0; i < 8; i++)
      begin
         nested_virt_bit_i = i[2];
         ret_auth_i = i[1];
         ret_b_key_i = i[0];
         exc(EXS_EV_RET, EXS_LVL_HYP, EXS_EC_RET_TRAP);
         check("return trap", hyp_syndrome_o & 64'hFFFFFFFF,
            synd(EXS_EC_RET_TRAP, {23'h0, i[1], i[1] & i[0]}));
      end
      nested_virt_bit_i = 1'b0;
      txn_dest_reg_i = 5'h15;
      exc(EXS_EV_TXN, EXS_LVL_HYP, EXS_EC_TXN_BEGIN);
      check("txn syndrome", hyp_syndrome_o & 64'hFFFFFFFF, synd(EXS_EC_TXN_BEGIN, 25'h2A0));
      for (int i = 1; i < 4; i++)
      begin
         branch_kind_state_i = i[1:0];
         exc(EXS_EV_BTI, EXS_LVL_HYP, EXS_EC_BRANCH_TGT);
         check("branch syndrome", hyp_syndrome_o & 64'hFFFFFFFF,
            synd(EXS_EC_BRANCH_TGT, 25'(i)));
      end
      // Authentication failures with each key family
      auth_fail_i = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         auth_data_key_i = i[1];
         auth_b_key_i = i[0];
         exc(EXS_EV_PFAIL, EXS_LVL_HYP, EXS_EC_PAUTH_FAIL);
         check("auth raise", 64'(auth_exc_o), 64'h1);
         check("auth syndrome", hyp_syndrome_o & 64'hFFFFFFFF,
            synd(EXS_EC_PAUTH_FAIL, 25'(i)));
      end
      auth_fail_i = 1'b0;
      $display("test exception layouts done");
      acc(EXS_LVL_APP, 1'b0, EXS_ENC_HYP, 64'h0, EXS_AC_UNDEF);
      acc(EXS_LVL_APP, 1'b1, EXS_ENC_KERN, 64'h0, EXS_AC_UNDEF);
      acc(EXS_LVL_KERN, 1'b1, EXS_ENC_KERN, 64'h0123456789ABCDEF, EXS_AC_OK);
      nested_virt_bit_i = 1'b1;
      acc(EXS_LVL_KERN, 1'b0, EXS_ENC_HYP, 64'h0, EXS_AC_TRAP);
      check("trap class", 64'(acc_trap_class_o), 64'(EXS_EC_SYSREG));
      nested_virt_memory_bit_i = 1'b1;
      acc(EXS_LVL_KERN, 1'b0, EXS_ENC_HYP, 64'h0, EXS_AC_OK);
      check("aliased read", rd, 64'h0123456789ABCDEF);
      nested_virt_kernel_bit_i = 1'b1;
      acc(EXS_LVL_KERN, 1'b0, EXS_ENC_KERN, 64'h0, EXS_AC_MEM);
      check("redirect offset", 64'(acc_mem_ofs_o), 64'h138);
      {nested_virt_bit_i, nested_virt_memory_bit_i, nested_virt_kernel_bit_i} = 3'h0;
      vm_read_trap_bit_i = 1'b1;
      acc(EXS_LVL_KERN, 1'b0, EXS_ENC_KERN, 64'h0, EXS_AC_TRAP);
      {vm_read_trap_bit_i, vm_write_trap_bit_i} = 2'h1;
      acc(EXS_LVL_KERN, 1'b1, EXS_ENC_KERN, 64'h0, EXS_AC_TRAP);
      {vm_write_trap_bit_i, fine_grain_trap_enable_i, fine_grain_read_trap_i} = 3'h3;
      acc(EXS_LVL_KERN, 1'b0, EXS_ENC_KERN, 64'h0, EXS_AC_TRAP);
      {fine_grain_read_trap_i, fine_grain_write_trap_i} = 2'h1;
      acc(EXS_LVL_KERN, 1'b1, EXS_ENC_KERN, 64'h0, EXS_AC_TRAP);
      fine_grain_write_trap_i = 1'b0;
      acc(EXS_LVL_KERN, 1'b0, EXS_ENC_KERN, 64'h0, EXS_AC_OK);
      check("refused writes kept", rd, 64'h0123456789ABCDEF);
      $display("test access control done");
      host_extension_bit_i = 1'b1;
      acc(EXS_LVL_HYP, 1'b1, EXS_ENC_KERN, 64'hA5, EXS_AC_OK);
      check("alias to hyp", hyp_syndrome_o, 64'hA5);
      host_extension_bit_i = 1'b0;
      acc(EXS_LVL_HYP, 1'b1, EXS_ENC_KERN, 64'h5A, EXS_AC_OK);
      check("hyp kept", hyp_syndrome_o, 64'hA5);
      acc(EXS_LVL_HYP, 1'b0, EXS_ENC_HYP, 64'h0, EXS_AC_OK);
      check("hyp read", rd, 64'hA5);
      acc(EXS_LVL_KERN, 1'b0, EXS_ENC_KERN, 64'h0, EXS_AC_OK);
      check("kernel written", rd, 64'h5A);
      // Monitor word: reserved top byte, low 56 bits inverted on return
      acc(EXS_LVL_MON, 1'b1, ENC_MON, 64'hFF123456789ABCDE, EXS_AC_OK);
      acc(EXS_LVL_MON, 1'b0, ENC_MON, 64'h0, EXS_AC_OK);
      check("mon top byte", rd, 64'h00123456789ABCDE);
      @(posedge clk_i);
      #1 monitor_return_i = 1'b1;
      @(posedge clk_i);
      #1 monitor_return_i = 1'b0;
      acc(EXS_LVL_MON, 1'b0, ENC_MON, 64'h0, EXS_AC_OK);
      check("mon after return", rd, 64'h00EDCBA987654321);
      $display("test aliases and monitor done");
      // Aborts, all wide stores: status register number only for data aborts with the listed faults
      wide_store_i = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         abort_fault_i = i[1:0];
         store_status_register_number_i = 5'h10 + 5'(i);
         exc(i[2] ? EXS_EV_IABT : EXS_EV_DABT, EXS_LVL_MON, 6'(i[2] ? 6'h20 : 6'h24) | 6'(i[0]));
         acc(EXS_LVL_MON, 1'b0, ENC_MON, 64'h0, EXS_AC_OK);
         check("extended field", rd >> 32,
            (i < 4 && i > 0) ? 64'h10 + 64'(i) : 64'h0);
      end
      $display("test abort extension done");
      give_verdict();
   end
endmodule
